// >>> rtl/bosm_top.sv
// Blade operational state machine with Wishbone registers and payload
// power control. Assumes board pins are asynchronous and that the chassis
// manager commands arrive as register writes.
//
// Overview of operation
// - Inactive and activation requested keep payload off.
// - Inactive to activation requested once insertion criteria met.
// - Deactivate command or extraction returns to inactive.
// - Activate command moves to activation in progress.
// - Payload power only after budget granted.
// - Rails up lets blade move to active.
// - Power failure, deactivate or extraction ends activation.
// - Active blade monitors and reports thermal, voltage warnings.
// - Policy deactivate in active requests deactivation.
// - Deactivate command in active forces deactivation.
// - Failure or payload power off forces deactivation.
// - Deactivation requested keeps power and budget.
// - Deactivate proceeds, activate returns to active.
// - Forcible conditions also apply in deactivation requested.
// - Deactivation in progress never reverses.
// - Orderly payload shutdown, forced off on timeout.
// - Completion revokes budget, clears policy, enters inactive.
// - Suspend to memory enters standby, keeping budget.
// - Standby returns straight to active.
// - Every transition is reported as an event.
// - Policy bit: commands, register writes, button change it.
// - Criteria combine policy with board conditions.
//
// Register access over Wishbone and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module bosm_top
  import bosm_pkg::*;
#(
  parameter int unsigned PWR_UP_TO = PWR_UP_TO_CYC,
  parameter int unsigned SHUT_TO = SHUT_TO_CYC
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic ins_ok_in,
  input wire logic ext_ok_in,
  input wire logic rails_good_in,
  input wire logic off_done_in,
  input wire logic pl_off_req_in,
  input wire logic hw_fault_in,
  input wire logic warn_therm_in,
  input wire logic warn_volt_in,
  input wire logic suspend_in,
  input wire logic wake_in,
  input wire logic btn_in,
  output logic payload_pwr_en_out,
  output logic graceful_off_req_out,
  output logic [6:0] state_out,
  output logic evt_strobe_out,
  output logic evt_pend_out
);
  bosm_pins_s raw;
  logic [PIN_W-1:0] meta_q;
  bosm_pins_s pin;
  logic btn_d_q;
  logic btn_press;
  bosm_state_e st_q;
  bosm_state_e st_d;
  logic policy_q;
  logic budget_q;
  logic therm_q;
  logic volt_q;
  logic cmd_act_q;
  logic cmd_deact_q;
  logic cmd_grant_q;
  bosm_evt_s evt_q;
  logic req;
  logic wr;
  logic [31:0] rd_d;
  logic on_req;
  logic seq_up;
  logic seq_fail;
  logic seq_off;
  logic extract;
  logic forcible;
  logic evt_clr;

  assign raw = '{btn: btn_in, wake: wake_in, suspend: suspend_in,
                 warn_volt: warn_volt_in, warn_therm: warn_therm_in,
                 hw_fault: hw_fault_in, pl_off_req: pl_off_req_in,
                 off_done: off_done_in, rails_good: rails_good_in,
                 ext_ok: ext_ok_in, ins_ok: ins_ok_in};

  // Two-stage synchroniser on every board pin
  for (genvar i = 0; i < PIN_W; i++) begin : g_sync
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
        meta_q[i] <= 1'b0;
        pin[i] <= 1'b0;
      end else if (ce_in) begin
        meta_q[i] <= raw[i];
        pin[i] <= meta_q[i];
      end
    end
  end

  // Button press edge, taken from the second stage only
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      btn_d_q <= 1'b0;
    end else if (ce_in) begin
      btn_d_q <= pin.btn;
    end
  end
  assign btn_press = pin.btn & ~btn_d_q;

  // Criteria and forcing conditions
  assign extract = ~policy_q & pin.ext_ok;
  assign forcible = pin.hw_fault | pin.pl_off_req | seq_fail;
  assign req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  assign wr = req & wb_we_in;
  assign evt_clr = wr & (wb_adr_in == ADR_EVT) & wb_sel_in[2]
                   & wb_dat_in[EVT_PEND_BIT];

  // Operational state transitions; deactivate wins over activate
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      INACTIVE_STATE: begin
        if (policy_q && pin.ins_ok) st_d = ACTIVATION_REQUESTED_STATE;
      end
      ACTIVATION_REQUESTED_STATE: begin
        if (cmd_deact_q || extract) st_d = INACTIVE_STATE;
        else if (cmd_act_q) st_d = ACTIVATION_IN_PROGRESS_STATE;
      end
      ACTIVATION_IN_PROGRESS_STATE: begin
        if (seq_fail || cmd_deact_q || extract) begin
          st_d = DEACTIVATION_IN_PROGRESS_STATE;
        end else if (seq_up) begin
          st_d = ACTIVE_RUNNING_STATE;
        end
      end
      ACTIVE_RUNNING_STATE: begin
        if (cmd_deact_q || forcible) begin
          st_d = DEACTIVATION_IN_PROGRESS_STATE;
        end else if (extract) begin
          st_d = DEACTIVATION_REQUESTED_STATE;
        end
      end
      DEACTIVATION_REQUESTED_STATE: begin
        if (cmd_deact_q || forcible) begin
          st_d = DEACTIVATION_IN_PROGRESS_STATE;
        end else if (cmd_act_q) begin
          st_d = ACTIVE_RUNNING_STATE;
        end
      end
      DEACTIVATION_IN_PROGRESS_STATE: begin
        // Commands are ignored here; only completion leaves
        if (seq_off) begin
          st_d = pin.suspend ? ACTIVE_STANDBY_STATE : INACTIVE_STATE;
        end
      end
      ACTIVE_STANDBY_STATE: begin
        if (pin.wake) st_d = ACTIVE_RUNNING_STATE;
      end
      default: st_d = INACTIVE_STATE;
    endcase
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q <= INACTIVE_STATE;
    end else if (ce_in) begin
      st_q <= st_d;
    end
  end
  assign state_out = st_q;

  // Payload power wanted once budget is held; off in inactive and requested
  assign on_req = (st_q == ACTIVATION_IN_PROGRESS_STATE && budget_q)
                  || st_q == ACTIVE_RUNNING_STATE
                  || st_q == DEACTIVATION_REQUESTED_STATE;

  bosm_pwr_seq #(
    .UP_TO(PWR_UP_TO),
    .DN_TO(SHUT_TO)
  ) u_seq (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .on_req_in(on_req),
    .rails_good_in(pin.rails_good),
    .off_done_in(pin.off_done),
    .pwr_en_out(payload_pwr_en_out),
    .graceful_out(graceful_off_req_out),
    .up_out(seq_up),
    .fail_out(seq_fail),
    .off_out(seq_off)
  );

  // Activation policy; finishing deactivation overrides everything else
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      policy_q <= POLICY_RST;
    end else if (ce_in) begin
      if (st_q == DEACTIVATION_IN_PROGRESS_STATE && st_d == INACTIVE_STATE) begin
        policy_q <= 1'b0;
      end else if (cmd_deact_q) begin
        policy_q <= 1'b0;
      end else if (cmd_act_q) begin
        policy_q <= 1'b1;
      end else if (wr && wb_adr_in == ADR_CTRL && wb_sel_in[0]) begin
        policy_q <= wb_dat_in[0];
      end else if (btn_press) begin
        policy_q <= ~policy_q;
      end
    end
  end

  // Power budget: granted before power-up, kept through standby
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      budget_q <= 1'b0;
    end else if (ce_in) begin
      if (st_d == INACTIVE_STATE) begin
        budget_q <= 1'b0;
      end else if (cmd_grant_q && st_q == ACTIVATION_IN_PROGRESS_STATE) begin
        budget_q <= 1'b1;
      end
    end
  end

  // Command strobes last one cycle after the register write
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cmd_act_q <= 1'b0;
      cmd_deact_q <= 1'b0;
      cmd_grant_q <= 1'b0;
    end else if (ce_in) begin
      cmd_act_q <= wr && wb_adr_in == ADR_CMD && wb_sel_in[0]
                   && wb_dat_in[CMD_ACT_BIT];
      cmd_deact_q <= wr && wb_adr_in == ADR_CMD && wb_sel_in[0]
                     && wb_dat_in[CMD_DEACT_BIT];
      cmd_grant_q <= wr && wb_adr_in == ADR_CMD && wb_sel_in[0]
                     && wb_dat_in[CMD_GRANT_BIT];
    end
  end

  // Sticky warnings while payload runs; a new warning beats the clear
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      therm_q <= 1'b0;
      volt_q <= 1'b0;
    end else if (ce_in) begin
      if (on_req && pin.warn_therm) begin
        therm_q <= 1'b1;
      end else if (wr && wb_adr_in == ADR_STATUS && wb_sel_in[1]
                   && wb_dat_in[STAT_THERM_BIT]) begin
        therm_q <= 1'b0;
      end
      if (on_req && pin.warn_volt) begin
        volt_q <= 1'b1;
      end else if (wr && wb_adr_in == ADR_STATUS && wb_sel_in[1]
                   && wb_dat_in[STAT_VOLT_BIT]) begin
        volt_q <= 1'b0;
      end
    end
  end

  // Transition record; an unread record that is replaced sets overrun
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      evt_q <= '{ovr: 1'b0, pend: 1'b0, to: INACTIVE_STATE, from: INACTIVE_STATE};
      evt_strobe_out <= 1'b0;
    end else if (ce_in) begin
      evt_strobe_out <= (st_d != st_q);
      if (st_d != st_q) begin
        evt_q.from <= st_q;
        evt_q.to <= st_d;
        evt_q.pend <= 1'b1;
        evt_q.ovr <= evt_q.ovr | (evt_q.pend & ~evt_clr);
      end else if (evt_clr) begin
        evt_q.pend <= 1'b0;
        evt_q.ovr <= 1'b0;
      end
    end
  end
  assign evt_pend_out = evt_q.pend;

  // Read mux; unmapped offsets read as zero
  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (wb_adr_in)
      ADR_CTRL: rd_d = {31'h0000_0000, policy_q};
      ADR_STATUS: rd_d = {19'h0_0000, volt_q, therm_q, payload_pwr_en_out,
                          budget_q, policy_q, 1'b0, st_q};
      ADR_EVT: rd_d = {14'h0000, evt_q.ovr, evt_q.pend, 1'b0, evt_q.to,
                       1'b0, evt_q.from};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // Single-cycle acknowledge, dropped after one cycle
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else if (ce_in) begin
      wb_ack_out <= req;
      if (req) wb_dat_out <= rd_d;
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  property p_idle_off;
    (st_q inside {INACTIVE_STATE, ACTIVATION_REQUESTED_STATE}) |-> !payload_pwr_en_out;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("payload on while idle");

  property p_insert;
    ce_in && st_q == INACTIVE_STATE && policy_q && pin.ins_ok
      |=> st_q == ACTIVATION_REQUESTED_STATE;
  endproperty
  a_insert: assert property (p_insert) else $error("insertion not taken");

  property p_m2_deact;
    ce_in && st_q == ACTIVATION_REQUESTED_STATE && cmd_deact_q |=> st_q == INACTIVE_STATE;
  endproperty
  a_m2_deact: assert property (p_m2_deact) else $error("deactivate ignored");

  sequence s_act_m2;
    ce_in && st_q == ACTIVATION_REQUESTED_STATE && cmd_act_q && !cmd_deact_q && !extract;
  endsequence
  property p_m2_act;
    s_act_m2 |=> st_q == ACTIVATION_IN_PROGRESS_STATE ##0 !payload_pwr_en_out;
  endproperty
  a_m2_act: assert property (p_m2_act) else $error("activate not taken");

  property p_budget;
    $rose(payload_pwr_en_out) |-> budget_q;
  endproperty
  a_budget: assert property (p_budget) else $error("power without budget");

  property p_m3_fail;
    ce_in && st_q == ACTIVATION_IN_PROGRESS_STATE && seq_fail
      |=> st_q == DEACTIVATION_IN_PROGRESS_STATE;
  endproperty
  a_m3_fail: assert property (p_m3_fail) else $error("power failure ignored");

  property p_m4_req;
    ce_in && st_q == ACTIVE_RUNNING_STATE && extract && !cmd_deact_q && !forcible
      |=> st_q == DEACTIVATION_REQUESTED_STATE;
  endproperty
  a_m4_req: assert property (p_m4_req) else $error("policy change ignored");

  property p_no_back;
    st_q == DEACTIVATION_IN_PROGRESS_STATE |=> st_q inside
      {DEACTIVATION_IN_PROGRESS_STATE, INACTIVE_STATE, ACTIVE_STANDBY_STATE};
  endproperty
  a_no_back: assert property (p_no_back) else $error("deactivation reversed");

  property p_done;
    st_q == INACTIVE_STATE && $past(st_q) == DEACTIVATION_IN_PROGRESS_STATE
      |-> !policy_q && !budget_q;
  endproperty
  a_done: assert property (p_done) else $error("completion left state");

  property p_evt;
    ce_in && st_d != st_q |=> evt_strobe_out && evt_q.pend && evt_q.to == st_q;
  endproperty
  a_evt: assert property (p_evt) else $error("transition not reported");
endmodule // bosm_top

// >>> rtl/bosm_pkg.sv
// Package for the blade operational state machine: register map, states,
// pin bundle, event record and timing.
// Assumes a 100 MHz controller clock and a classic Wishbone register bus.
package bosm_pkg;
  // Clock rate, used to derive every cycle count
  localparam int unsigned CLK_MHZ = 100;
  // Longest wait for payload rails to come up, in microseconds
  localparam int unsigned PWR_UP_TO_US = 10000;
  // Longest wait for an orderly payload shutdown, in microseconds
  localparam int unsigned SHUT_TO_US = 5000000;
  localparam int unsigned PWR_UP_TO_CYC = PWR_UP_TO_US * CLK_MHZ;
  localparam int unsigned SHUT_TO_CYC = SHUT_TO_US * CLK_MHZ;

  // Register byte offsets
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_CMD = 8'h04;
  localparam logic [7:0] ADR_STATUS = 8'h08;
  localparam logic [7:0] ADR_EVT = 8'h0c;

  // Field positions
  localparam int CMD_ACT_BIT = 0;
  localparam int CMD_DEACT_BIT = 1;
  localparam int CMD_GRANT_BIT = 2;
  localparam int STAT_THERM_BIT = 11;
  localparam int STAT_VOLT_BIT = 12;
  localparam int EVT_PEND_BIT = 16;

  // Policy after reset: activate, so a blade without extra criteria moves on
  localparam logic POLICY_RST = 1'b1;

  typedef enum logic [6:0] {
    INACTIVE_STATE = 7'h01,
    ACTIVATION_REQUESTED_STATE = 7'h02,
    ACTIVATION_IN_PROGRESS_STATE = 7'h04,
    ACTIVE_RUNNING_STATE = 7'h08,
    DEACTIVATION_REQUESTED_STATE = 7'h10,
    DEACTIVATION_IN_PROGRESS_STATE = 7'h20,
    ACTIVE_STANDBY_STATE = 7'h40
  } bosm_state_e;

  typedef enum logic [4:0] {
    PS_OFF = 5'h01,
    PS_RAMP = 5'h02,
    PS_ON = 5'h04,
    PS_SHUT = 5'h08,
    PS_FAIL = 5'h10
  } bosm_pwr_e;

  // Board-level inputs, all asynchronous to the controller clock
  typedef struct packed {
    logic btn;
    logic wake;
    logic suspend;
    logic warn_volt;
    logic warn_therm;
    logic hw_fault;
    logic pl_off_req;
    logic off_done;
    logic rails_good;
    logic ext_ok;
    logic ins_ok;
  } bosm_pins_s;

  localparam int PIN_W = $bits(bosm_pins_s);

  // Last reported transition
  typedef struct packed {
    logic ovr;
    logic pend;
    bosm_state_e to;
    bosm_state_e from;
  } bosm_evt_s;
endpackage

// >>> rtl/bosm_pwr_seq.sv
// Payload power sequencer: ramps rails with a timeout, shuts down orderly
// and forces power off when the payload does not answer in time.
// Assumes rails_good and off_done are already synchronised.
`timescale 1ns/1ps
module bosm_pwr_seq
  import bosm_pkg::*;
#(
  parameter int unsigned UP_TO = PWR_UP_TO_CYC,
  parameter int unsigned DN_TO = SHUT_TO_CYC
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic on_req_in,
  input wire logic rails_good_in,
  input wire logic off_done_in,
  output logic pwr_en_out,
  output logic graceful_out,
  output logic up_out,
  output logic fail_out,
  output logic off_out
);
  bosm_pwr_e ps_q;
  bosm_pwr_e ps_d;
  logic [31:0] cnt_q;

  // Sequencer next state; a ramp that times out counts as a failure
  always_comb begin
    ps_d = ps_q;
    unique case (ps_q)
      PS_OFF: if (on_req_in) ps_d = PS_RAMP;
      PS_RAMP: begin
        if (!on_req_in) ps_d = PS_SHUT;
        else if (rails_good_in) ps_d = PS_ON;
        else if (cnt_q == 32'(UP_TO - 1)) ps_d = PS_FAIL;
      end
      PS_ON: begin
        if (!on_req_in) ps_d = PS_SHUT;
        else if (!rails_good_in) ps_d = PS_FAIL;
      end
      PS_SHUT: begin
        if (off_done_in || cnt_q == 32'(DN_TO - 1)) ps_d = PS_OFF;
      end
      PS_FAIL: if (!on_req_in) ps_d = PS_OFF;
      default: ps_d = PS_OFF;
    endcase
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ps_q <= PS_OFF;
    end else if (ce_in) begin
      ps_q <= ps_d;
    end
  end

  // Timeout counter restarts on every state change
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q <= 32'h0000_0000;
    end else if (ce_in) begin
      cnt_q <= (ps_d != ps_q) ? 32'h0000_0000 : cnt_q + 32'h0000_0001;
    end
  end

  // Outputs from flops; power stays on during an orderly shutdown
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pwr_en_out <= 1'b0;
      graceful_out <= 1'b0;
      up_out <= 1'b0;
      fail_out <= 1'b0;
      off_out <= 1'b1;
    end else if (ce_in) begin
      pwr_en_out <= ps_d inside {PS_RAMP, PS_ON, PS_SHUT};
      graceful_out <= (ps_d == PS_SHUT);
      up_out <= (ps_d == PS_ON);
      fail_out <= (ps_d == PS_FAIL);
      off_out <= (ps_d == PS_OFF);
    end
  end
endmodule // bosm_pwr_seq

// >>> tb/bosm_payload_model.sv
// Payload model: rails come up a while after power is enabled, and an
// orderly shutdown finishes a while after it is asked for.
// Assumes the bench clock; stall inputs make the payload unresponsive.
`timescale 1ns/1ps
module bosm_payload_model #(
  parameter int RAMP = 6,
  parameter int DONE = 8
) (
  input wire logic ref_clk_in,
  input wire logic pwr_en_in,
  input wire logic off_req_in,
  input wire logic stall_up_in,
  input wire logic stall_dn_in,
  output logic rails_good_out,
  output logic off_done_out
);
  int up_q;
  int dn_q;
  // Count how long power and the shutdown request have been standing
  always_ff @(posedge ref_clk_in) begin
    up_q <= (pwr_en_in && !stall_up_in) ? up_q + 1 : 0;
    dn_q <= (off_req_in && !stall_dn_in) ? dn_q + 1 : 0;
  end
  // Rails drop at once with the enable, so no stale good level survives
  assign rails_good_out = pwr_en_in && (up_q >= RAMP);
  assign off_done_out = off_req_in && (dn_q >= DONE);
endmodule // bosm_payload_model

// >>> tb/bosm_top_bench.sv
// Bench for the blade state machine: Wishbone register tasks, board pins
// driven at clock edges, payload model on the power pins.
// Assumes the short timeouts set below.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
  $display("wrong value at %0t: %h %h", $time, a, b); end end
module bosm_top_bench;
  import bosm_pkg::*;
  localparam int UP_TO = 20;
  localparam int DN_TO = 40;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack;
  logic ins_ok = 1'b0;
  logic ext_ok = 1'b1;
  logic pl_off = 1'b0;
  logic hw_fault = 1'b0;
  logic warn_t = 1'b0;
  logic warn_v = 1'b0;
  logic suspend = 1'b0;
  logic wake = 1'b0;
  logic btn = 1'b0;
  logic stall_up = 1'b0;
  logic stall_dn = 1'b0;
  logic rails_good;
  logic off_done;
  logic pwr_en;
  logic grace;
  logic evt_stb;
  logic evt_pend;
  logic [6:0] state;
  logic [6:0] state_prev = 7'h01;
  int miscompares = 0;
  int n_tests = 0;
  int n_evt = 0;
  int n_chg = 0;

  always #5 clk = ~clk;

  bosm_top #(.PWR_UP_TO(UP_TO), .SHUT_TO(DN_TO)) dut (
    .ref_clk_in(clk), .rst_in(rst), .ce_in(ce),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
    .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .ins_ok_in(ins_ok), .ext_ok_in(ext_ok), .rails_good_in(rails_good),
    .off_done_in(off_done), .pl_off_req_in(pl_off), .hw_fault_in(hw_fault),
    .warn_therm_in(warn_t), .warn_volt_in(warn_v), .suspend_in(suspend),
    .wake_in(wake), .btn_in(btn), .payload_pwr_en_out(pwr_en),
    .graceful_off_req_out(grace), .state_out(state),
    .evt_strobe_out(evt_stb), .evt_pend_out(evt_pend)
  );

  bosm_payload_model payload (
    .ref_clk_in(clk), .pwr_en_in(pwr_en), .off_req_in(grace),
    .stall_up_in(stall_up), .stall_dn_in(stall_dn),
    .rails_good_out(rails_good), .off_done_out(off_done)
  );

  // Tally state changes and event pulses; they must match one for one.
  // The blade only ever shows one of its own seven one-hot codes.
  always @(posedge clk) begin
    if (!rst && evt_stb === 1'b1) n_evt++;
    if (!rst && state !== state_prev) n_chg++;
    if (!rst) `CHK($onehot(state), 1'b1)
    state_prev = state;
  end

  // One classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) miscompares++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // Pins pass a synchroniser, so allow a bounded settling time
  task automatic wait_st(input logic [6:0] s);
    int n;
    n = 0;
    while (state !== s && n < 300) begin
      @(posedge clk);
      n++;
    end
    `CHK(state, s)
  endtask

  // Overrun is expected whenever an unread record was replaced
  task automatic chk_evt(input logic o, input logic [6:0] f, input logic [6:0] t);
    wb(1'b0, ADR_EVT, 32'h0000_0000);
    `CHK(q[17:0], {o, 2'b10, t, 1'b0, f})
    wb(1'b1, ADR_EVT, 32'h0001_0000);
  endtask

  // Walk to activation in progress; power must wait for the budget
  task automatic go_act(input logic grant);
    wb(1'b1, ADR_CTRL, 32'h0000_0001);
    wait_st(ACTIVATION_REQUESTED_STATE);
    wb(1'b1, ADR_CMD, 32'h0000_0001);
    wait_st(ACTIVATION_IN_PROGRESS_STATE);
    repeat (10) @(posedge clk);
    `CHK(pwr_en, 1'b0)
    if (grant) wb(1'b1, ADR_CMD, 32'h0000_0004);
  endtask

  task automatic test_done;
    if (miscompares == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    test_done();
  end

  initial begin
    repeat (8) @(posedge clk);
    `CHK(state, INACTIVE_STATE)
    `CHK(pwr_en, 1'b0)
    rst <= 1'b0;
    repeat (10) @(posedge clk);
    `CHK(state, INACTIVE_STATE)
    ins_ok <= 1'b1;
    wait_st(ACTIVATION_REQUESTED_STATE);
    `CHK(pwr_en, 1'b0)
    chk_evt(1'b0, INACTIVE_STATE, ACTIVATION_REQUESTED_STATE);
    wb(1'b1, ADR_CMD, 32'h0000_0002);
    wait_st(INACTIVE_STATE);
    wb(1'b0, 8'h10, 32'h0000_0000);
    `CHK(q, 32'h0000_0000)
    wb(1'b0, ADR_CTRL, 32'h0000_0000);
    `CHK(q, 32'h0000_0000)
    go_act(1'b1);
    wait_st(ACTIVE_RUNNING_STATE);
    `CHK(pwr_en, 1'b1)
    // Warnings are sticky until written back
    warn_t <= 1'b1;
    warn_v <= 1'b1;
    repeat (5) @(posedge clk);
    warn_t <= 1'b0;
    warn_v <= 1'b0;
    repeat (4) @(posedge clk);
    wb(1'b0, ADR_STATUS, 32'h0000_0000);
    `CHK(q[12:0], 13'h1f08)
    wb(1'b1, ADR_STATUS, 32'h0000_1800);
    wb(1'b0, ADR_STATUS, 32'h0000_0000);
    `CHK(q[12:11], 2'h0)
    wb(1'b1, ADR_CTRL, 32'h0000_0000);
    wait_st(DEACTIVATION_REQUESTED_STATE);
    wb(1'b0, ADR_STATUS, 32'h0000_0000);
    `CHK(q[10:9], 2'h3)
    wb(1'b1, ADR_CMD, 32'h0000_0001);
    wait_st(ACTIVE_RUNNING_STATE);
    wb(1'b1, ADR_CTRL, 32'h0000_0000);
    wait_st(DEACTIVATION_REQUESTED_STATE);
    hw_fault <= 1'b1;
    wait_st(DEACTIVATION_IN_PROGRESS_STATE);
    hw_fault <= 1'b0;
    wait_st(INACTIVE_STATE);
    wb(1'b0, ADR_STATUS, 32'h0000_0000);
    `CHK(q[9:8], 2'h0)
    // Commanded stop with a payload that never finishes its shutdown
    stall_dn <= 1'b1;
    go_act(1'b1);
    wait_st(ACTIVE_RUNNING_STATE);
    wb(1'b1, ADR_CMD, 32'h0000_0002);
    wait_st(DEACTIVATION_IN_PROGRESS_STATE);
    chk_evt(1'b1, ACTIVE_RUNNING_STATE, DEACTIVATION_IN_PROGRESS_STATE);
    wb(1'b1, ADR_CMD, 32'h0000_0001);
    repeat (DN_TO - 20) @(posedge clk);
    `CHK(state, DEACTIVATION_IN_PROGRESS_STATE)
    `CHK({grace, pwr_en}, 2'h3)
    wait_st(INACTIVE_STATE);
    `CHK(pwr_en, 1'b0)
    stall_dn <= 1'b0;
    // Payload turns itself off, then the OS suspends to memory
    go_act(1'b1);
    wait_st(ACTIVE_RUNNING_STATE);
    pl_off <= 1'b1;
    wait_st(DEACTIVATION_IN_PROGRESS_STATE);
    pl_off <= 1'b0;
    suspend <= 1'b1;
    wait_st(ACTIVE_STANDBY_STATE);
    wb(1'b0, ADR_STATUS, 32'h0000_0000);
    `CHK(q[9], 1'b1)
    suspend <= 1'b0;
    wake <= 1'b1;
    wait_st(ACTIVE_RUNNING_STATE);
    wake <= 1'b0;
    wb(1'b1, ADR_CMD, 32'h0000_0002);
    wait_st(INACTIVE_STATE);
    // Rails never come up, so the ramp times out
    stall_up <= 1'b1;
    go_act(1'b1);
    wait_st(DEACTIVATION_IN_PROGRESS_STATE);
    stall_up <= 1'b0;
    wait_st(INACTIVE_STATE);
    // Extraction needs the board condition as well as the policy
    ext_ok <= 1'b0;
    go_act(1'b0);
    wb(1'b1, ADR_CTRL, 32'h0000_0000);
    repeat (10) @(posedge clk);
    `CHK(state, ACTIVATION_IN_PROGRESS_STATE)
    ext_ok <= 1'b1;
    wait_st(DEACTIVATION_IN_PROGRESS_STATE);
    wait_st(INACTIVE_STATE);
    btn <= 1'b1;
    repeat (4) @(posedge clk);
    btn <= 1'b0;
    wait_st(ACTIVATION_REQUESTED_STATE);
    repeat (2) @(posedge clk);
    `CHK(n_evt, n_chg)
    `CHK(evt_pend, 1'b1)
    // A frozen block must not see the button, so the policy stays put
    ce <= 1'b0;
    btn <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK(state, ACTIVATION_REQUESTED_STATE)
    btn <= 1'b0;
    ce <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK(state, ACTIVATION_REQUESTED_STATE)
    test_done();
  end
endmodule // bosm_top_bench
